// file: rtl/match_timer.sv
// one channel of an 8-bit compare-match timer with three interrupt lines
// ------------------------------------------------------------------
// What this block does
// - three sources: match a, match b, wrap
// - match a request: flag and enable, highest
// - match b request: flag and enable, middle
// - wrap request: flag and enable, lowest
// - each request on its own line
// - clear select 01 clears counter on a
// - select 0110: high on a, low b
// - clear-on-a plus 0110 gives autonomous pulses
// - clear beats counter write, write dropped
// - counter write beats increment, increment skipped
// - constant write suppresses that compare match
// - coincident matches resolved by fixed priority
// - priority: toggle, then high, then low
// - increment on falling edge of source
// - select change high to low increments once
// - stopped select is low level
// - internal/external switch may spuriously increment
// - match flag set in last equal state
// - wrap flag set on ff to 00
// ------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module match_timer
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // cpu write port, final-state strobes
   input wire match_timer_pkg::write_req_s write_req,
   // control bits
   input wire logic clear_sel_hi,
   input wire logic clear_sel_lo,
   input wire logic [3:0] output_action_sel,
   input wire logic clk_src_sel_1,
   input wire logic clk_src_sel_0,
   input wire logic [3:0] int_clk_src,
   input wire logic ext_clk_sel,
   input wire logic ext_clk_pin,
   input wire logic ext_reset_pin,
   input wire logic match_a_irq_en,
   input wire logic match_b_irq_en,
   input wire logic wrap_irq_en,
   // software flag clears, one-cycle pulses
   input wire match_timer_pkg::irq_flags_s flag_clear,
   // status
   output logic [7:0] count_value,
   output logic [7:0] time_const_a,
   output logic [7:0] time_const_b,
   output match_timer_pkg::irq_flags_s flags,
   // interrupt requests
   output logic match_a_irq,
   output logic match_b_irq,
   output logic wrap_irq,
   // timer output
   output logic timer_pulse_out
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] ext_clk_sync_reg;
   logic [1:0] ext_rst_sync_reg;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         ext_clk_sync_reg <= 2'h0;
         ext_rst_sync_reg <= 2'h0;
      end
      else
      begin
         ext_clk_sync_reg <= {ext_clk_sync_reg[0], ext_clk_pin};
         ext_rst_sync_reg <= {ext_rst_sync_reg[0], ext_reset_pin};
      end
   end

   // ---------------------------------------------------------------
   // clock source selection and edge detect
   // ---------------------------------------------------------------
   logic src_level;
   logic src_level_reg;
   logic ext_rst_prev_reg;
   logic count_pulse;
   logic ext_clear;

   always_comb
   begin
      // stopped selection reads as low
      if (ext_clk_sel)
         src_level = ext_clk_sync_reg[1];
      else if ({clk_src_sel_1, clk_src_sel_0} == 2'h0)
         src_level = 1'b0;
      else
         src_level = int_clk_src[{clk_src_sel_1, clk_src_sel_0}];
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         src_level_reg <= 1'b0;
         ext_rst_prev_reg <= 1'b0;
      end
      else
      begin
         src_level_reg <= src_level;
         ext_rst_prev_reg <= ext_rst_sync_reg[1];
      end
   end

   // a source switch from high to low is itself a falling edge
   assign count_pulse = src_level_reg & ~src_level;
   assign ext_clear = ext_rst_sync_reg[1] & ~ext_rst_prev_reg;

   // ---------------------------------------------------------------
   // compare match detect
   // ---------------------------------------------------------------
   logic [1:0] clear_sel;
   logic match_a;
   logic match_b;
   logic wrap;
   logic counter_clear;

   assign clear_sel = {clear_sel_hi, clear_sel_lo};
   // match fires in last equal state, as counter advances
   assign match_a = count_pulse && (count_value == time_const_a)
      && !write_req.const_a_we;
   assign match_b = count_pulse && (count_value == time_const_b)
      && !write_req.const_b_we;
   assign wrap = count_pulse && (count_value == match_timer_pkg::COUNT_MAX)
      && !counter_clear && !write_req.count_we;
   assign counter_clear = (clear_sel == match_timer_pkg::CLEAR_ON_A
      && match_a)
      || (clear_sel == match_timer_pkg::CLEAR_ON_B && match_b)
      || (clear_sel == match_timer_pkg::CLEAR_EXT && ext_clear);

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (reset)
         count_value <= match_timer_pkg::COUNT_RESET;
      else if (counter_clear)
         count_value <= match_timer_pkg::COUNT_RESET;
      else if (write_req.count_we)
         count_value <= write_req.wdata;
      else if (count_pulse)
         count_value <= count_value + 8'h01;
   end

   // ---------------------------------------------------------------
   // time constants
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         time_const_a <= match_timer_pkg::CONST_RESET;
         time_const_b <= match_timer_pkg::CONST_RESET;
      end
      else
      begin
         if (write_req.const_a_we)
            time_const_a <= write_req.wdata;
         if (write_req.const_b_we)
            time_const_b <= write_req.wdata;
      end
   end

   // ---------------------------------------------------------------
   // flags, set wins over clear
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (reset)
         flags <= '0;
      else
      begin
         flags.match_a <= match_a
            | (flags.match_a & ~flag_clear.match_a);
         flags.match_b <= match_b
            | (flags.match_b & ~flag_clear.match_b);
         flags.wrap <= wrap | (flags.wrap & ~flag_clear.wrap);
      end
   end

   // ---------------------------------------------------------------
   // interrupt requests, separate lines
   // ---------------------------------------------------------------
   assign match_a_irq = flags.match_a & match_a_irq_en;
   assign match_b_irq = flags.match_b & match_b_irq_en;
   assign wrap_irq = flags.wrap & wrap_irq_en;

   // ---------------------------------------------------------------
   // timer output
   // ---------------------------------------------------------------
   match_timer_pkg::out_action_e act_a;
   match_timer_pkg::out_action_e act_b;
   match_timer_pkg::out_action_e act;
   logic out_next;

   assign act_a = match_timer_pkg::out_action_e'(output_action_sel[1:0]);
   assign act_b = match_timer_pkg::out_action_e'(output_action_sel[3:2]);

   always_comb
   begin
      // coincident: toggle over high over low
      if (match_a && match_b)
      begin
         if (act_a == match_timer_pkg::ACT_TOGGLE
            || act_b == match_timer_pkg::ACT_TOGGLE)
            act = match_timer_pkg::ACT_TOGGLE;
         else if (act_a == match_timer_pkg::ACT_HIGH
            || act_b == match_timer_pkg::ACT_HIGH)
            act = match_timer_pkg::ACT_HIGH;
         else if (act_a == match_timer_pkg::ACT_LOW
            || act_b == match_timer_pkg::ACT_LOW)
            act = match_timer_pkg::ACT_LOW;
         else
            act = match_timer_pkg::ACT_KEEP;
      end
      else if (match_a)
         act = act_a;
      else if (match_b)
         act = act_b;
      else
         act = match_timer_pkg::ACT_KEEP;
      case (act)
         match_timer_pkg::ACT_LOW: out_next = 1'b0;
         match_timer_pkg::ACT_HIGH: out_next = 1'b1;
         match_timer_pkg::ACT_TOGGLE: out_next = ~timer_pulse_out;
         default: out_next = timer_pulse_out;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         timer_pulse_out <= 1'b0;
      else
         timer_pulse_out <= out_next;
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_irq_a_follows: assert property (
      match_a_irq == (flags.match_a && match_a_irq_en))
      else $error("match a request wrong");
   a_irq_b_follows: assert property (
      match_b_irq == (flags.match_b && match_b_irq_en))
      else $error("match b request wrong");
   a_irq_wrap_follows: assert property (
      wrap_irq == (flags.wrap && wrap_irq_en))
      else $error("wrap request wrong");
   a_clear_on_a: assert property (
      match_a && clear_sel == 2'h1 |=> count_value == 8'h00)
      else $error("no clear on match a");
   a_write_beats_inc: assert property (
      write_req.count_we && !counter_clear
      |=> count_value == $past(write_req.wdata))
      else $error("count write lost");
   a_const_write_block: assert property (
      write_req.const_a_we && !flags.match_a |=> !flags.match_a)
      else $error("match a not suppressed");
   a_set_high_on_a: assert property (
      match_a && !match_b && output_action_sel == 4'h6 |=> timer_pulse_out)
      else $error("output not high on match a");
   a_low_on_b: assert property (
      match_b && !match_a && output_action_sel == 4'h6 |=> !timer_pulse_out)
      else $error("output not low on match b");
   a_wrap_flag_set: assert property (
      count_pulse && count_value == 8'hFF && !counter_clear
      && !write_req.count_we |=> flags.wrap && count_value == 8'h00)
      else $error("wrap flag not set");
   a_stopped_low: assert property (
      !ext_clk_sel && !clk_src_sel_1 && !clk_src_sel_0 && $past(src_level)
      |-> count_pulse)
      else $error("stop not seen as edge");

   // ---------------------------------------------------------------
   // contention and coincidence
   // ---------------------------------------------------------------
   a_const_b_block: assert property (
      write_req.const_b_we && !flags.match_b |=> !flags.match_b)
      else $error("match b not suppressed");
   a_clear_beats_write: assert property (
      counter_clear && write_req.count_we |=> count_value == 8'h00)
      else $error("count write beat a clear");
   a_wrap_write_skip: assert property (
      count_pulse && count_value == 8'hFF && write_req.count_we
      && !flags.wrap |=> !flags.wrap)
      else $error("wrap flag set on a count write");
   a_coincide_toggle: assert property (
      match_a && match_b && (output_action_sel[3:2] == 2'h3
      || output_action_sel[1:0] == 2'h3)
      |=> timer_pulse_out != $past(timer_pulse_out))
      else $error("coincident toggle lost");
   a_coincide_high: assert property (
      match_a && match_b && output_action_sel[3:2] != 2'h3
      && output_action_sel[1:0] != 2'h3
      && (output_action_sel[3] || output_action_sel[1]) |=> timer_pulse_out)
      else $error("coincident high lost");
   a_coincide_low: assert property (
      match_a && match_b && !output_action_sel[3] && !output_action_sel[1]
      && (output_action_sel[2] || output_action_sel[0])
      |=> !timer_pulse_out)
      else $error("coincident low lost");

   // ---------------------------------------------------------------
   // counting and flags
   // ---------------------------------------------------------------
   a_inc_on_fall: assert property (
      count_pulse && !counter_clear && !write_req.count_we
      |=> count_value == 8'($past(count_value) + 8'h01))
      else $error("count did not advance");
   a_hold_when_idle: assert property (
      !count_pulse && !counter_clear && !write_req.count_we
      |=> $stable(count_value))
      else $error("count moved without a pulse");
   a_match_a_flag: assert property (
      count_pulse && count_value == time_const_a && !write_req.const_a_we
      |=> flags.match_a)
      else $error("match a flag not set");
   a_stop_no_count: assert property (
      !ext_clk_sel && !clk_src_sel_1 && !clk_src_sel_0 && !src_level_reg
      |-> !count_pulse)
      else $error("stopped source counted");
   a_wrap_from_max: assert property (
      $rose(flags.wrap)
      |-> count_value == 8'h00 && $past(count_value) == 8'hFF)
      else $error("wrap flag without overflow");

   c_pulse_mode: cover property (clear_sel == 2'h1 && match_a
      && output_action_sel == 4'h6);
   c_coincide: cover property (match_a && match_b);
   c_wrap: cover property (wrap);
   c_clear_vs_write: cover property (counter_clear && write_req.count_we);
   c_ext_clear: cover property (ext_clear && clear_sel == 2'h3);

endmodule : match_timer

`default_nettype wire

// file: rtl/match_timer_pkg.sv
// constants and carrier types for the 8-bit compare-match timer channel
package match_timer_pkg;

   // ----------------------------------------------------------------
   // field layouts and reset values
   // ----------------------------------------------------------------
   localparam int COUNT_W = 8;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] CONST_RESET = 8'hFF;
   localparam logic [1:0] CLEAR_SEL_RESET = 2'h0;
   localparam logic [3:0] OUT_SEL_RESET = 4'h0;

   // ----------------------------------------------------------------
   // counter clear select codes (hi, lo)
   // ----------------------------------------------------------------
   localparam logic [1:0] CLEAR_NONE = 2'h0;
   localparam logic [1:0] CLEAR_ON_A = 2'h1;
   localparam logic [1:0] CLEAR_ON_B = 2'h2;
   localparam logic [1:0] CLEAR_EXT = 2'h3;

   // ----------------------------------------------------------------
   // output action codes, per compare channel
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ACT_KEEP = 2'b00,
      ACT_LOW = 2'b01,
      ACT_HIGH = 2'b10,
      ACT_TOGGLE = 2'b11
   } out_action_e;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic count_we;
      logic const_a_we;
      logic const_b_we;
      logic [7:0] wdata;
   } write_req_s;

   typedef struct packed
   {
      logic match_a;
      logic match_b;
      logic wrap;
   } irq_flags_s;

endpackage : match_timer_pkg

// file: test/irq_ctrl_model.sv
// interrupt controller model granting one request by priority
`timescale 1ns/100ps
`default_nettype none

module irq_ctrl_model
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // request lines, one per source
   input wire logic match_a_irq,
   input wire logic match_b_irq,
   input wire logic wrap_irq,
   // granted source: 0 none, 1 a, 2 b, 3 wrap
   output logic [1:0] grant
);
   always_ff @(posedge core_clk)
   begin
      if (reset)
         grant <= 2'h0;
      else if (match_a_irq)
         grant <= 2'h1;
      else if (match_b_irq)
         grant <= 2'h2;
      else if (wrap_irq)
         grant <= 2'h3;
      else
         grant <= 2'h0;
   end
endmodule : irq_ctrl_model
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the compare-match timer channel
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic core_clk;
   logic reset;
   match_timer_pkg::write_req_s write_req;
   match_timer_pkg::irq_flags_s flag_clear;
   match_timer_pkg::irq_flags_s flags;
   logic clear_sel_hi;
   logic clear_sel_lo;
   logic [3:0] output_action_sel;
   logic clk_src_sel_1;
   logic clk_src_sel_0;
   logic [3:0] int_clk_src;
   logic ext_clk_sel;
   logic ext_clk_pin;
   logic ext_reset_pin;
   logic match_a_irq_en;
   logic match_b_irq_en;
   logic wrap_irq_en;
   logic [7:0] count_value;
   logic [7:0] time_const_a;
   logic [7:0] time_const_b;
   logic match_a_irq;
   logic match_b_irq;
   logic wrap_irq;
   logic timer_pulse_out;
   logic [1:0] grant;
   logic exp_out;
   int n_mismatch;
   int comparisons;

   match_timer dut
   (
      .core_clk, .reset, .write_req, .clear_sel_hi, .clear_sel_lo,
      .output_action_sel, .clk_src_sel_1, .clk_src_sel_0, .int_clk_src,
      .ext_clk_sel, .ext_clk_pin, .ext_reset_pin,
      .match_a_irq_en, .match_b_irq_en, .wrap_irq_en, .flag_clear,
      .count_value, .time_const_a, .time_const_b, .flags,
      .match_a_irq, .match_b_irq, .wrap_irq, .timer_pulse_out
   );

   irq_ctrl_model partner
   (
      .core_clk, .reset, .match_a_irq, .match_b_irq, .wrap_irq, .grant
   );

   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // compare, access and report tasks
   // ------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask : chk1

   task automatic final_report;
      if (n_mismatch == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report

   function automatic match_timer_pkg::write_req_s req(input logic [2:0] we,
      input logic [7:0] d);
      return {we, d};
   endfunction : req

   // expected output after coincident matches
   function automatic logic resolve(input logic [3:0] s, input logic cur);
      if (s[3:2] == 2'h3 || s[1:0] == 2'h3)
         return ~cur;
      if (s[3] || s[1])
         return 1'b1;
      if (s[2] || s[0])
         return 1'b0;
      return cur;
   endfunction : resolve

   task automatic wr(input match_timer_pkg::write_req_s w);
      @(posedge core_clk);
      write_req <= w;
      @(posedge core_clk);
      write_req <= '0;
   endtask : wr

   // one falling edge of source 1, with a write in that cycle
   task automatic tick(input match_timer_pkg::write_req_s w);
      @(posedge core_clk);
      int_clk_src[1] <= 1'b1;
      @(posedge core_clk);
      int_clk_src[1] <= 1'b0;
      write_req <= w;
      @(posedge core_clk);
      write_req <= '0;
      @(posedge core_clk);
      @(negedge core_clk);
   endtask : tick

   task automatic cfg(input logic [1:0] clr, input logic [3:0] os,
      input logic [1:0] src, input logic [2:0] en);
      @(posedge core_clk);
      {clear_sel_hi, clear_sel_lo} <= clr;
      output_action_sel <= os;
      {clk_src_sel_1, clk_src_sel_0} <= src;
      {match_a_irq_en, match_b_irq_en, wrap_irq_en} <= en;
      @(negedge core_clk);
   endtask : cfg

   task automatic clear(input logic [2:0] c);
      @(posedge core_clk);
      flag_clear <= c;
      @(posedge core_clk);
      flag_clear <= '0;
      @(posedge core_clk);
      @(negedge core_clk);
   endtask : clear

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      reset = 1'b1;
      write_req = '0;
      flag_clear = '0;
      {clear_sel_hi, clear_sel_lo, clk_src_sel_1, clk_src_sel_0} = 4'h0;
      output_action_sel = 4'h0;
      int_clk_src = 4'h0;
      {ext_clk_sel, ext_clk_pin, ext_reset_pin} = 3'h0;
      {match_a_irq_en, match_b_irq_en, wrap_irq_en} = 3'h0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      @(negedge core_clk);
      chk1(match_a_irq, 1'b0);
      cfg(2'h0, 4'h0, 2'h1, 3'h0);
      wr(req(3'h4, 8'h10));
      tick('0);
      chk8(count_value, 8'h11);
      tick(req(3'h4, 8'h20));
      chk8(count_value, 8'h20);
      // pulse setup: clear on a, high on a, low on b
      cfg(2'h1, 4'h6, 2'h1, 3'h7);
      wr(req(3'h2, 8'h05));
      wr(req(3'h1, 8'h03));
      wr(req(3'h4, 8'h03));
      @(negedge core_clk);
      chk8(time_const_a, 8'h05);
      chk8(time_const_b, 8'h03);
      tick('0);
      chk1(flags.match_b, 1'b1);
      chk1(match_b_irq, 1'b1);
      tick('0);
      tick('0);
      chk8(count_value, 8'h00);
      chk1(timer_pulse_out, 1'b1);
      chk1(match_a_irq, 1'b1);
      chk8({6'h00, grant}, 8'h01);
      clear(3'h4);
      chk1(match_a_irq, 1'b0);
      chk8({6'h00, grant}, 8'h02);
      cfg(2'h1, 4'h6, 2'h1, 3'h5);
      chk1(match_b_irq, 1'b0);
      repeat (4) tick('0);
      chk1(timer_pulse_out, 1'b0);
      clear(3'h7);
      wr(req(3'h4, 8'h05));
      tick(req(3'h4, 8'h77));
      chk8(count_value, 8'h00);
      clear(3'h7);
      wr(req(3'h4, 8'h05));
      tick(req(3'h2, 8'h05));
      chk1(flags.match_a, 1'b0);
      chk8(count_value, 8'h06);
      cfg(2'h0, 4'h0, 2'h1, 3'h7);
      wr(req(3'h4, 8'hFF));
      tick('0);
      chk8(count_value, 8'h00);
      chk1(flags.wrap, 1'b1);
      chk1(wrap_irq, 1'b1);
      chk8({6'h00, grant}, 8'h03);
      // count write at ff skips the increment and the wrap
      clear(3'h1);
      wr(req(3'h4, 8'hFF));
      tick(req(3'h4, 8'h12));
      chk1(flags.wrap, 1'b0);
      chk8(count_value, 8'h12);
      // clear on match b
      cfg(2'h2, 4'h0, 2'h1, 3'h7);
      wr(req(3'h4, 8'h03));
      tick('0);
      chk8(count_value, 8'h00);
      // equal constants, every output select code
      wr(req(3'h3, 8'h40));
      @(negedge core_clk);
      chk8(time_const_b, 8'h40);
      exp_out = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         cfg(2'h0, i[3:0], 2'h1, 3'h7);
         wr(req(3'h4, 8'h40));
         tick('0);
         exp_out = resolve(i[3:0], exp_out);
         chk1(timer_pulse_out, exp_out);
      end
      // source changes: high to low, then high to stopped
      wr(req(3'h4, 8'h00));
      @(posedge core_clk);
      int_clk_src <= 4'h2;
      cfg(2'h0, 4'h0, 2'h2, 3'h7);
      @(negedge core_clk);
      chk8(count_value, 8'h01);
      cfg(2'h0, 4'h0, 2'h1, 3'h7);
      cfg(2'h0, 4'h0, 2'h0, 3'h7);
      @(negedge core_clk);
      chk8(count_value, 8'h02);
      // internal high to external low, then one external falling edge
      cfg(2'h0, 4'h0, 2'h1, 3'h7);
      @(posedge core_clk);
      ext_clk_sel <= 1'b1;
      repeat (2) @(negedge core_clk);
      chk8(count_value, 8'h03);
      @(posedge core_clk);
      ext_clk_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      ext_clk_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk8(count_value, 8'h04);
      // external reset rising edge clears the counter
      cfg(2'h3, 4'h0, 2'h1, 3'h7);
      @(posedge core_clk);
      ext_reset_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_reset_pin <= 1'b0;
      @(negedge core_clk);
      chk8(count_value, 8'h00);
      final_report();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      final_report();
   end
endmodule : tb
`default_nettype wire
